// ---- shared/smpd_params.svh ----
/*
  smpd_params.svh: offsets, field positions, reset values and counts for the
  modulator and power-down control block.
  assumes: included by bare name by the package and the design modules.
*/
`ifndef SMPD_PARAMS_SVH
`define SMPD_PARAMS_SVH

// register byte offsets
`define SMPD_OFS_MOD_CFG 12'h000
`define SMPD_OFS_PD_CFG 12'h004
`define SMPD_OFS_DIV_VAL 12'h008
`define SMPD_OFS_FRAC 12'h00C
`define SMPD_OFS_STATUS 12'h010
`define SMPD_OFS_TEST 12'h014

// mod_cfg fields
`define SMPD_MOD_ORDER_LSB 0
`define SMPD_DITHER_LSB 4
`define SMPD_SLIP_LSB 8
// pd_cfg fields
`define SMPD_MAIN_PD_BIT 0
`define SMPD_AUX_PD_BIT 1
`define SMPD_AUTOPU_BIT 2
// test fields
`define SMPD_TMUX_LSB 0

// reset values: third order, no dither, slip reduction off
`define SMPD_MOD_ORDER_RST 2'h3
`define SMPD_DITHER_RST 2'h0
`define SMPD_SLIP_RST 2'h0
`define SMPD_DIV_RST 23'h000000
`define SMPD_FRAC_RST 24'h000000
`define SMPD_TMUX_RST 2'h0

// lock detect: consecutive good comparisons before lock
`define SMPD_LOCK_COUNT 3'h5
// fastlock timeout length in comparison cycles
`define SMPD_FAST_TIMEOUT 14'h0100

`endif

// ---- shared/smpd_pkg.sv ----
/*
  smpd_pkg.sv: types of the modulator and power-down control block.
  assumes: smpd_params.svh is on the include path.
*/
package smpd_pkg;
  `include "smpd_params.svh"

  // modulator order select encodings
  typedef enum logic [1:0] {
    SMPD_ORDER4 = 2'h0,
    SMPD_ORDER_RSVD = 2'h1,
    SMPD_ORDER2 = 2'h2,
    SMPD_ORDER3 = 2'h3
  } smpd_order_t;

  // dither level encodings
  typedef enum logic [1:0] {
    SMPD_DITHER_LEVEL_OFF = 2'h0,
    SMPD_DITHER_LEVEL_WEAK = 2'h1,
    SMPD_DITHER_LEVEL_STRONG = 2'h2,
    SMPD_DITHER_LEVEL_RSVD = 2'h3
  } smpd_dither_t;

  // slip reduction factor encodings
  typedef enum logic [1:0] {
    SMPD_SLIP_OFF = 2'h0,
    SMPD_SLIP_HALF = 2'h1,
    SMPD_SLIP_QUARTER = 2'h2,
    SMPD_SLIP_SIXTEENTH = 2'h3
  } smpd_slip_t;

  // test output selection
  typedef enum logic [1:0] {
    SMPD_TMUX_LOW = 2'h0,
    SMPD_TMUX_LOCK_MAIN = 2'h1,
    SMPD_TMUX_LOCK_AUX = 2'h2,
    SMPD_TMUX_LOCK_BOTH = 2'h3
  } smpd_tmux_t;

  // loop acquisition state
  typedef enum logic [1:0] {
    SMPD_ST_IDLE = 2'b00,
    SMPD_ST_ACQ = 2'b01,
    SMPD_ST_TRACK = 2'b10
  } smpd_state_t;
endpackage

// ---- design/smpd_lock_ctr.sv ----
/*
  smpd_lock_ctr.sv: per-loop lock detect and fastlock timeout counters.
  assumes: comp_tick_i is a one-cycle enable per comparison cycle; clear_i is
  a one-cycle pulse on a divider write; clk_i is the only clock.
*/
`include "smpd_params.svh"
module smpd_lock_ctr
  import smpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic powered_i,
  input wire logic clear_i,
  input wire logic comp_tick_i,
  input wire logic phase_ok_i,
  output logic locked_o,
  output logic fast_active_o
);
  logic [2:0] good_reg;
  logic [13:0] tmo_reg;
  smpd_state_t state_reg;

  // acquisition state: a divider write restarts acquisition
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !powered_i) begin
      state_reg <= SMPD_ST_IDLE;
    end else if (clear_i) begin
      state_reg <= SMPD_ST_ACQ;
    end else begin
      case (state_reg)
        SMPD_ST_IDLE: state_reg <= SMPD_ST_IDLE;
        SMPD_ST_ACQ: begin
          if (comp_tick_i && tmo_reg == 14'h0001) begin
            state_reg <= SMPD_ST_TRACK;
          end
        end
        SMPD_ST_TRACK: state_reg <= SMPD_ST_TRACK;
        default: state_reg <= SMPD_ST_IDLE;
      endcase
    end
  end

  // fastlock timeout counter, reloaded on divider write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !powered_i) begin
      tmo_reg <= 14'h0000;
    end else if (clear_i) begin
      tmo_reg <= `SMPD_FAST_TIMEOUT;
    end else if (comp_tick_i && tmo_reg != 14'h0000) begin
      tmo_reg <= tmo_reg - 14'h0001;
    end
  end

  // lock counter: five good comparisons in a row to declare lock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !powered_i || clear_i) begin
      good_reg <= 3'h0;
      locked_o <= 1'b0;
    end else if (comp_tick_i) begin
      if (!phase_ok_i) begin
        good_reg <= 3'h0;
        locked_o <= 1'b0;
      end else if (good_reg == `SMPD_LOCK_COUNT - 3'h1) begin
        locked_o <= 1'b1;
      end else begin
        good_reg <= good_reg + 3'h1;
      end
    end
  end

  assign fast_active_o = (state_reg == SMPD_ST_ACQ);
endmodule // smpd_lock_ctr

// ---- design/smpd_top.sv ----
/*
  smpd_top.sv: modulator settings and power-down control of a dual
  synthesizer, registers on an AHB-Lite slave.
  assumes: one 50 MHz clock, synchronous active-low reset, a single master
  doing single word transfers; chip_en_i may change at any time.
*/
`include "smpd_params.svh"
module smpd_top
  import smpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic chip_en_i,
  input wire logic [1:0] phase_ok_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic main_powered_o,
  output logic aux_powered_o,
  output logic [1:0] modulator_order_o,
  output logic [1:0] dither_level_o,
  output logic [1:0] slip_reduction_factor_o,
  output logic [4:0] comp_div_o,
  output logic [1:0] fast_active_o,
  output logic test_out_o
);
  import smpd_pkg::*;

  smpd_order_t modulator_order_sel_reg;
  smpd_dither_t dither_level_reg;
  smpd_slip_t slip_reduction_factor_reg;
  smpd_tmux_t tmux_reg;
  logic main_loop_powerdown_reg;
  logic aux_loop_powerdown_reg;
  logic auto_powerup_on_divider_write_reg;
  logic [22:0] div_reg;
  logic [23:0] frac_reg;
  logic [1:0] autopu_hold_reg;
  logic [3:0] tick_cnt_reg;
  logic [11:0] wr_addr_reg;
  logic wr_pend_reg;
  logic [31:0] rd_next;
  logic div_write;
  logic [1:0] powered;
  logic [1:0] locked;
  logic comp_tick;
  logic lock_view;
  logic [1:0] ctr_on;

  // word address match, decoded in several places
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // slip factor as a divide ratio of the comparison rate
  function automatic logic [4:0] slip_div(input smpd_slip_t f);
    case (f)
      SMPD_SLIP_HALF: slip_div = 5'h02;
      SMPD_SLIP_QUARTER: slip_div = 5'h04;
      SMPD_SLIP_SIXTEENTH: slip_div = 5'h10;
      default: slip_div = 5'h01;
    endcase
  endfunction

  // bus: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // capture write address phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr[11:0];
    end
  end

  assign div_write = wr_pend_reg && hit(wr_addr_reg, `SMPD_OFS_DIV_VAL);

  // configuration registers; only a bus write or reset changes them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      modulator_order_sel_reg <= smpd_order_t'(`SMPD_MOD_ORDER_RST);
      dither_level_reg <= smpd_dither_t'(`SMPD_DITHER_RST);
      slip_reduction_factor_reg <= smpd_slip_t'(`SMPD_SLIP_RST);
      main_loop_powerdown_reg <= 1'b0;
      aux_loop_powerdown_reg <= 1'b0;
      auto_powerup_on_divider_write_reg <= 1'b0;
      div_reg <= `SMPD_DIV_RST;
      frac_reg <= `SMPD_FRAC_RST;
      tmux_reg <= smpd_tmux_t'(`SMPD_TMUX_RST);
    end else if (wr_pend_reg) begin
      if (hit(wr_addr_reg, `SMPD_OFS_MOD_CFG)) begin
        modulator_order_sel_reg <= smpd_order_t'(hwdata[`SMPD_MOD_ORDER_LSB +: 2]);
        dither_level_reg <= smpd_dither_t'(hwdata[`SMPD_DITHER_LSB +: 2]);
        slip_reduction_factor_reg <= smpd_slip_t'(hwdata[`SMPD_SLIP_LSB +: 2]);
      end
      if (hit(wr_addr_reg, `SMPD_OFS_PD_CFG)) begin
        main_loop_powerdown_reg <= hwdata[`SMPD_MAIN_PD_BIT];
        aux_loop_powerdown_reg <= hwdata[`SMPD_AUX_PD_BIT];
        auto_powerup_on_divider_write_reg <= hwdata[`SMPD_AUTOPU_BIT];
      end
      if (div_write) begin
        div_reg <= hwdata[22:0];
      end
      if (hit(wr_addr_reg, `SMPD_OFS_FRAC)) begin
        frac_reg <= hwdata[23:0];
      end
      if (hit(wr_addr_reg, `SMPD_OFS_TEST)) begin
        tmux_reg <= smpd_tmux_t'(hwdata[`SMPD_TMUX_LSB +: 2]);
      end
    end
  end

  // auto power-up latch: divider write overrides pd bit until pd reprogrammed or chip_en_i goes low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !chip_en_i) begin
      autopu_hold_reg <= 2'b00;
    end else if (div_write && auto_powerup_on_divider_write_reg) begin
      autopu_hold_reg <= 2'b11;
    end else if (wr_pend_reg && hit(wr_addr_reg, `SMPD_OFS_PD_CFG)) begin
      autopu_hold_reg <= 2'b00;
    end
  end

  // power state is combinational so enable and pd bits act at once
  assign powered[0] = chip_en_i && (!main_loop_powerdown_reg || autopu_hold_reg[0]);
  assign powered[1] = chip_en_i && (!aux_loop_powerdown_reg || autopu_hold_reg[1]);
  assign main_powered_o = powered[0];
  assign aux_powered_o = powered[1];

  // counters wake on the very divider write that triggers auto power-up
  assign ctr_on = powered | {2{chip_en_i && div_write && auto_powerup_on_divider_write_reg}};

  // comparison tick divider, slowed by the slip factor while the main loop is in acquisition
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick_cnt_reg == 4'h0 || div_write) begin
      tick_cnt_reg <= fast_active_o[0] ? 4'(slip_div(slip_reduction_factor_reg) - 5'h01) : 4'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 4'h1;
    end
  end
  assign comp_tick = (tick_cnt_reg == 4'h0);

  // per-loop lock and timeout counters
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_loop
      smpd_lock_ctr u_ctr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .powered_i(ctr_on[g]),
        .clear_i(div_write),
        .comp_tick_i(comp_tick),
        .phase_ok_i(phase_ok_i[g]),
        .locked_o(locked[g]),
        .fast_active_o(fast_active_o[g])
      );
    end
  endgenerate

  // test output: lock view forced low while a viewed loop is down
  always_comb begin
    case (tmux_reg)
      SMPD_TMUX_LOCK_MAIN: lock_view = powered[0] && locked[0];
      SMPD_TMUX_LOCK_AUX: lock_view = powered[1] && locked[1];
      SMPD_TMUX_LOCK_BOTH: lock_view = &(powered & locked);
      default: lock_view = 1'b0;
    endcase
  end
  assign test_out_o = lock_view;

  // settings to the modulator
  assign modulator_order_o = modulator_order_sel_reg;
  assign dither_level_o = dither_level_reg;
  assign slip_reduction_factor_o = slip_reduction_factor_reg;
  assign comp_div_o = slip_div(slip_reduction_factor_reg);

  // read mux
  always_comb begin
    rd_next = 32'h00000000;
    if (hit(haddr[11:0], `SMPD_OFS_MOD_CFG)) begin
      rd_next[`SMPD_MOD_ORDER_LSB +: 2] = modulator_order_sel_reg;
      rd_next[`SMPD_DITHER_LSB +: 2] = dither_level_reg;
      rd_next[`SMPD_SLIP_LSB +: 2] = slip_reduction_factor_reg;
    end else if (hit(haddr[11:0], `SMPD_OFS_PD_CFG)) begin
      rd_next[`SMPD_MAIN_PD_BIT] = main_loop_powerdown_reg;
      rd_next[`SMPD_AUX_PD_BIT] = aux_loop_powerdown_reg;
      rd_next[`SMPD_AUTOPU_BIT] = auto_powerup_on_divider_write_reg;
    end else if (hit(haddr[11:0], `SMPD_OFS_DIV_VAL)) begin
      rd_next[22:0] = div_reg;
    end else if (hit(haddr[11:0], `SMPD_OFS_FRAC)) begin
      rd_next[23:0] = frac_reg;
    end else if (hit(haddr[11:0], `SMPD_OFS_STATUS)) begin
      rd_next[7:0] = {fast_active_o, locked, autopu_hold_reg, powered};
    end else if (hit(haddr[11:0], `SMPD_OFS_TEST)) begin
      rd_next[1:0] = tmux_reg;
    end
  end

  // read data registered at the address phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_next;
    end
  end
endmodule // smpd_top

// ---- verification/smpd_top_assertions.sv ----
/* smpd_top_assertions.sv: port checker for smpd_top.
   assumes: bound into smpd_top; one clock; hreadyout feeds hready. */
`include "smpd_params.svh"
module smpd_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic chip_en_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic main_powered_o,
  input wire logic aux_powered_o,
  input wire logic [1:0] modulator_order_o,
  input wire logic [1:0] dither_level_o,
  input wire logic [1:0] slip_reduction_factor_o,
  input wire logic [4:0] comp_div_o,
  input wire logic test_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_reg;
  logic apu_reg;
  logic [11:0] wa_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // write data phase flag and auto power-up shadow
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_reg <= 1'b0;
      apu_reg <= 1'b0;
    end else begin
      wr_reg <= hsel && htrans[1] && hready && hwrite;
      if (wr_reg && wa_reg == `SMPD_OFS_PD_CFG) apu_reg <= hwdata[2];
    end
  end
  // address held for the data phase
  always_ff @(posedge clk_i) wa_reg <= haddr[11:0];
  property p_ce_off;
    !chip_en_i |-> !main_powered_o && !aux_powered_o;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("powered with chip enable low");
  property p_div;
    comp_div_o == (slip_reduction_factor_o == 2'h0 ? 5'h01 : slip_reduction_factor_o == 2'h1 ? 5'h02 :
                   slip_reduction_factor_o == 2'h2 ? 5'h04 : 5'h10);
  endproperty
  a_div: assert property (p_div) else $error("wrong slip divide ratio");
  property p_mod;
    wr_reg && wa_reg == `SMPD_OFS_MOD_CFG |=>
      modulator_order_o == $past(hwdata[1:0]) && dither_level_o == $past(hwdata[5:4]);
  endproperty
  a_mod: assert property (p_mod) else $error("order or dither not taken");
  property p_slip;
    wr_reg && wa_reg == `SMPD_OFS_MOD_CFG |=> slip_reduction_factor_o == $past(hwdata[9:8]);
  endproperty
  a_slip: assert property (p_slip) else $error("slip factor not taken");
  property p_pd_main;
    wr_reg && wa_reg == `SMPD_OFS_PD_CFG && hwdata[2:0] == 3'h1 |=>
      !main_powered_o && aux_powered_o == chip_en_i;
  endproperty
  a_pd_main: assert property (p_pd_main) else $error("main power-down wrong");
  property p_pd_clr;
    wr_reg && wa_reg == `SMPD_OFS_PD_CFG && hwdata[1:0] == 2'h0 |=>
      main_powered_o == chip_en_i && aux_powered_o == chip_en_i;
  endproperty
  a_pd_clr: assert property (p_pd_clr) else $error("section down with bits clear");
  property p_apu;
    wr_reg && wa_reg == `SMPD_OFS_DIV_VAL && apu_reg |=>
      main_powered_o == chip_en_i && aux_powered_o == chip_en_i;
  endproperty
  a_apu: assert property (p_apu) else $error("auto power-up missing");
  property p_lock_low;
    !main_powered_o && !aux_powered_o |-> !test_out_o;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock view high while down");
  property p_keep;
    !chip_en_i && !wr_reg |=> $stable(modulator_order_o) && $stable(dither_level_o);
  endproperty
  a_keep: assert property (p_keep) else $error("settings lost in power-down");
  c_apu: cover property (wr_reg && apu_reg && wa_reg == `SMPD_OFS_DIV_VAL);
  c_ce: cover property ($fell(chip_en_i));
  c_lock: cover property (test_out_o);
endmodule // smpd_chk
bind smpd_top smpd_chk smpd_chk_inst (.clk_i, .rst_n_i, .chip_en_i, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .main_powered_o, .aux_powered_o, .modulator_order_o, .dither_level_o, .slip_reduction_factor_o,
  .comp_div_o, .test_out_o);

// ---- verification/smpd_host.sv ----
/* smpd_host.sv: host model, AHB-Lite master of single word transfers.
   assumes: hready is the slave's hreadyout; tasks called from the bench. */
module smpd_host (
  input wire logic clk_i,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // one transfer; each phase held until hready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata; // released data no longer valid
  endtask
endmodule // smpd_host

// ---- verification/testbench.sv ----
/* testbench.sv: self-checking bench of smpd_top.
   assumes: smpd_host drives the bus; smpd_chk is bound in. */
`include "smpd_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, chip_en_i, hsel, hwrite, hreadyout, hresp;
  logic main_powered_o, aux_powered_o, test_out_o;
  logic [1:0] phase_ok_i, htrans, modulator_order_o, dither_level_o, slip_reduction_factor_o, fast_active_o;
  logic [2:0] hsize;
  logic [4:0] comp_div_o;
  logic [31:0] haddr, hwdata, hrdata, q;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  smpd_top smpd_top_inst (.clk_i, .rst_n_i, .chip_en_i, .phase_ok_i, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_powered_o, .aux_powered_o,
    .modulator_order_o, .dither_level_o, .slip_reduction_factor_o, .comp_div_o, .fast_active_o, .test_out_o);
  smpd_host smpd_host_inst (.clk_i, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    smpd_host_inst.xfer(1'b1, a, d, q);
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    smpd_host_inst.xfer(1'b0, a, 32'h00000000, q);
    #1;
  endtask
  task automatic t_reset();
    rd(`SMPD_OFS_MOD_CFG);
    chk(q, 32'h00000003);
    rd(12'h020);
    chk(q, 32'h00000000);
    chk(32'(hresp), 32'h00000000);
    chk(32'(hreadyout), 32'h00000001);
    $display("t_reset done");
  endtask
  // order written before dither on every pass
  task automatic t_codes();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`SMPD_OFS_MOD_CFG, 32'(c));
      wr(`SMPD_OFS_MOD_CFG, {22'h000000, c, 2'h0, c, 2'h0, c});
      chk(32'({modulator_order_o, dither_level_o, slip_reduction_factor_o}), 32'({c, c, c}));
      chk(32'(comp_div_o), c == 2'h0 ? 32'h1 : c == 2'h1 ? 32'h2 : c == 2'h2 ? 32'h4 : 32'h10);
      chk(32'(comp_div_o) * (c == 2'h1 ? 32'h8 : c == 2'h2 ? 32'h4 : 32'h1), c == 2'h0 ? 32'h1 : 32'h10);
    end
    $display("t_codes done");
  endtask
  task automatic t_pd();
    wr(`SMPD_OFS_FRAC, 32'h00000FFF);
    for (int p = 0; p < 4; p++) begin
      wr(`SMPD_OFS_PD_CFG, 32'(p));
      chk(32'({main_powered_o, aux_powered_o}), 32'({~p[0], ~p[1]}));
    end
    rd(`SMPD_OFS_MOD_CFG);
    chk(q, 32'h00000333);
    rd(`SMPD_OFS_FRAC);
    chk(q, 32'h00000FFF);
    $display("t_pd done");
  endtask
  task automatic t_apu();
    wr(`SMPD_OFS_PD_CFG, 32'h00000007);
    chk(32'({main_powered_o, aux_powered_o}), 32'h0);
    wr(`SMPD_OFS_DIV_VAL, 32'h00000123);
    chk(32'({main_powered_o, aux_powered_o}), 32'h3);
    chk(32'(fast_active_o), 32'h3);
    rd(`SMPD_OFS_DIV_VAL);
    chk(q, 32'h00000123);
    wr(`SMPD_OFS_PD_CFG, 32'h00000003);
    chk(32'({main_powered_o, aux_powered_o}), 32'h0);
    $display("t_apu done");
  endtask
  task automatic t_lock();
    wr(`SMPD_OFS_MOD_CFG, 32'h00000003);
    wr(`SMPD_OFS_PD_CFG, 32'h00000000);
    wr(`SMPD_OFS_TEST, 32'h00000001);
    wr(`SMPD_OFS_DIV_VAL, 32'h00000002);
    for (int n = 0; n < 1000 && test_out_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk(32'(test_out_o), 32'h1);
    @(posedge clk_i);
    chip_en_i <= 1'b0;
    #1;
    chk(32'({main_powered_o, aux_powered_o, test_out_o}), 32'h0);
    @(posedge clk_i);
    chip_en_i <= 1'b1;
    #1;
    chk(32'({main_powered_o, aux_powered_o}), 32'h3);
    rd(`SMPD_OFS_MOD_CFG);
    chk(q, 32'h00000003);
    $display("t_lock done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    chip_en_i = 1'b1;
    phase_ok_i = 2'h3;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_codes();
    t_pd();
    t_apu();
    t_lock();
    wrap_up();
  end
endmodule // testbench
